//--- logic/sensor_device.sv
// sensor end of the link: command decode, conversion, result shift-out
//
// Behaviour
// - capture din and launch dout on sclk rise
// - host changes din, samples dout on fall
// - host alone drives sclk, starts exchanges
// - last command selects data put on dout
// - command opens with three high bits
// - command closes with three low bits
// - four-bit select field picks one of four
// - dout rises on final stop bit for conversions
// - host gives two clocks after acknowledge
// - host holds sclk low during conversion
// - dout falls when conversion completes
// - seventeen clocks shift out sixteen result bits
// - paused sclk holds the shift position
// - host reads result before next conversion
// - resync pattern returns link to idle anywhere
// - resync is 21 bits; dout ignored meanwhile
// - host sends resync before first conversion
// - four 16-bit calibration words held on-chip
// - pressure and temperature share one converter
// - sensing element powered only briefly
// - host may read calibration words from idle, any number of times
// - host supplies a 32.768 kHz master clock
`timescale 1ns/100ps
module sensor_device
  import sensor_link_pkg::*;
#(
  parameter int          CONV_LEN   = CONV_MCLK,
  parameter int          POWER_LEN  = SENSOR_ON_MCLK,
  // arbitrary calibration contents, words one to four from the top
  parameter logic [63:0] CALIB_DATA = 64'h1357_2468_9BDF_ACE0
) (
  // clock and reset
  input  logic          clk,
  input  logic          rst,
  input  logic          ce,
  // master clock from the system
  input  logic          mclk,
  // converter inputs
  input  logic [15:0]   pressure_raw,
  input  logic [15:0]   temperature_raw,
  // status
  output logic          sensor_power,
  output logic          conv_busy,
  // link
  sensor_link_if.device link
);

  localparam int MW = $clog2(CONV_LEN + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_ACK  = 4'h2,
    D_CONV = 4'h4,
    D_DATA = 4'h8
  } dev_state_t;

  typedef struct packed {
    dev_state_t       state;
    logic [20:0]      hist;
    logic [31:0]      sh;
    logic [5:0]       cnt;
    logic [MW-1:0]    mcnt;
    logic             is_temp;
    logic             dout;
    logic             power;
    logic             busy;
    logic             sclk_q;
    logic             mclk_q;
  } dev_regs_t;

  dev_regs_t r;
  dev_regs_t next_r;

  logic [2:0] pins_s;
  logic       sclk_s;
  logic       din_s;
  logic       mclk_s;
  logic       rise;
  logic       mrise;
  logic [3:0] sel;

  generate
    if (CONV_LEN < 2 || POWER_LEN < 1 || POWER_LEN >= CONV_LEN)
    begin : g_chk
      $error("sensor_device needs 1 <= POWER_LEN < CONV_LEN");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync_2ff #(
    .WIDTH (3)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({link.sclk, link.din, mclk}),
    .q   (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign din_s  = pins_s[1];
  assign mclk_s = pins_s[0];
  assign rise   = sclk_s & ~r.sclk_q;
  assign mrise  = mclk_s & ~r.mclk_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.sclk_q = sclk_s;
    next_r.mclk_q = mclk_s;
    sel           = '0;
    if (rise)
      next_r.hist = {r.hist[19:0], din_s};
    case (r.state)
      D_IDLE:
      begin
        sel = next_r.hist[6:3];
        if (rise && next_r.hist[9:7] == START_BITS && next_r.hist[2:0] == STOP_BITS)
        begin
          if (sel == SEL_PRESSURE || sel == SEL_TEMPERATURE)
          begin
            next_r.is_temp = (sel == SEL_TEMPERATURE);
            next_r.dout    = 1'b1;
            next_r.cnt     = ACK_CLOCKS;
            next_r.state   = D_ACK;
          end
          else if (sel == SEL_CAL_13)
          begin
            next_r.sh    = {CALIB_DATA[63:48], CALIB_DATA[31:16]};
            next_r.cnt   = CAL_BITS;
            next_r.state = D_DATA;
          end
          else if (sel == SEL_CAL_24)
          begin
            next_r.sh    = {CALIB_DATA[47:32], CALIB_DATA[15:0]};
            next_r.cnt   = CAL_BITS;
            next_r.state = D_DATA;
          end
        end
      end
      D_ACK:
      begin
        // the two trailing clocks keep dout high and start the conversion
        if (rise)
        begin
          next_r.cnt = r.cnt - 6'h01;
          if (r.cnt == 6'h01)
          begin
            next_r.mcnt  = '0;
            next_r.power = 1'b1;
            next_r.busy  = 1'b1;
            next_r.state = D_CONV;
          end
        end
      end
      D_CONV:
      begin
        // paced by mclk only, so a stopped sclk cannot stall it
        if (mrise)
        begin
          next_r.mcnt = r.mcnt + MW'(1);
          if (r.mcnt == MW'(POWER_LEN - 1))
            next_r.power = 1'b0;
          if (r.mcnt == MW'(CONV_LEN - 1))
          begin
            // one converter: the last command picks which input is taken
            next_r.sh    = {r.is_temp ? temperature_raw : pressure_raw, 16'h0000};
            next_r.cnt   = CONV_BITS;
            next_r.dout  = 1'b0;
            next_r.busy  = 1'b0;
            next_r.power = 1'b0;
            next_r.state = D_DATA;
          end
        end
      end
      D_DATA:
      begin
        // nothing moves without a rise, so a held sclk pauses the readout
        if (rise)
        begin
          if (r.cnt == 6'h00)
          begin
            next_r.dout  = 1'b0;
            next_r.state = D_IDLE;
          end
          else
          begin
            next_r.dout = r.sh[31];
            next_r.sh   = {r.sh[30:0], 1'b0};
            next_r.cnt  = r.cnt - 6'h01;
          end
        end
      end
      default:
      begin
        next_r.state = D_IDLE;
      end
    endcase
    // resync wins over every state; history is cleared so it fires once
    if (rise && next_r.hist == RESYNC_PATTERN)
    begin
      next_r.hist  = '0;
      next_r.dout  = 1'b0;
      next_r.power = 1'b0;
      next_r.busy  = 1'b0;
      next_r.state = D_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r       <= '0;
      r.state <= D_IDLE;
    end
    else if (ce)
      r <= next_r;
  end

  assign link.dout    = r.dout;
  assign sensor_power = r.power;
  assign conv_busy    = r.busy;

endmodule : sensor_device

//--- logic/sensor_host.sv
// host end of the link: makes sclk, sends commands, reads results
`timescale 1ns/100ps
module sensor_host
  import sensor_link_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC
) (
  // clock and reset
  input  logic        clk,
  input  logic        rst,
  input  logic        ce,
  // command
  input  logic        cmd_valid,
  input  host_cmd_t   cmd_code,
  output logic        cmd_ready,
  // result
  output logic        result_valid,
  output logic [31:0] result_data,
  // link
  sensor_link_if.host link
);

  localparam int TW = $clog2(SCLK_HALF + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SEND = 5'h02,
    H_ACK  = 5'h04,
    H_WAIT = 5'h08,
    H_READ = 5'h10
  } host_state_t;

  typedef struct packed {
    host_state_t   state;
    host_cmd_t     code;
    logic [TW-1:0] tmr;
    logic [5:0]    left;
    logic [20:0]   tx;
    logic [32:0]   rx;
    logic          sclk;
    logic          din;
    logic          ready;
    logic          rvalid;
    logic [31:0]   rdata;
  } host_regs_t;

  host_regs_t r;
  host_regs_t next_r;

  logic       dout_s;
  logic       step;
  logic       fall;
  logic [3:0] sel;

  generate
    // dout answers five clk after a rise (three in the sensor, two here),
    // so a shorter half period would sample the previous bit on the fall
    if (SCLK_HALF < 6)
    begin : g_chk
      $error("sensor_host needs SCLK_HALF of at least 6");
    end
  endgenerate

  sync_2ff #(
    .WIDTH (1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (link.dout),
    .q   (dout_s)
  );

  assign step = (r.tmr == TW'(SCLK_HALF - 1));
  assign fall = step & r.sclk;

  always_comb
  begin
    case (cmd_code)
      CMD_PRESSURE:    sel = SEL_PRESSURE;
      CMD_TEMPERATURE: sel = SEL_TEMPERATURE;
      CMD_CAL_13:      sel = SEL_CAL_13;
      default:         sel = SEL_CAL_24;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    if (r.state == H_SEND || r.state == H_ACK || r.state == H_READ)
    begin
      // only the host makes sclk; din moves and dout is sampled on the fall
      next_r.tmr = step ? '0 : r.tmr + TW'(1);
      if (step)
        next_r.sclk = ~r.sclk;
      if (fall)
      begin
        next_r.rx   = {r.rx[31:0], dout_s};
        next_r.tx   = {r.tx[19:0], 1'b0};
        next_r.din  = r.tx[19];
        next_r.left = r.left - 6'h01;
      end
    end
    case (r.state)
      H_IDLE:
      begin
        next_r.ready = 1'b1;
        if (cmd_valid)
        begin
          next_r.ready = 1'b0;
          next_r.code  = cmd_code;
          next_r.tmr   = '0;
          next_r.state = H_SEND;
          if (cmd_code == CMD_RESYNC)
          begin
            next_r.tx   = RESYNC_PATTERN;
            next_r.left = 6'(RESYNC_LEN);
          end
          else
          begin
            next_r.tx   = {START_BITS, sel, STOP_BITS, 11'h000};
            next_r.left = 6'(CMD_LEN);
          end
          next_r.din = next_r.tx[20];
        end
      end
      H_SEND:
      begin
        // dout is not looked at while a pattern goes out
        if (fall && r.left == 6'h01)
        begin
          next_r.din = 1'b0;
          if (r.code == CMD_RESYNC)
            next_r.state = H_IDLE;
          else if (r.code == CMD_PRESSURE || r.code == CMD_TEMPERATURE)
          begin
            next_r.left  = ACK_CLOCKS;
            next_r.state = H_ACK;
          end
          else
          begin
            next_r.rx    = '0;
            next_r.left  = CAL_READ_CLKS;
            next_r.state = H_READ;
          end
        end
      end
      H_ACK:
      begin
        if (fall && r.left == 6'h01)
          next_r.state = H_WAIT;
      end
      H_WAIT:
      begin
        // sclk stays low until the sensor pulls dout down
        if (!dout_s)
        begin
          next_r.rx    = '0;
          next_r.tmr   = '0;
          next_r.left  = CONV_READ_CLKS;
          next_r.state = H_READ;
        end
      end
      H_READ:
      begin
        // the whole result is taken before a new command is accepted
        if (fall && r.left == 6'h01)
        begin
          next_r.rdata  = next_r.rx[32:1];
          next_r.rvalid = 1'b1;
          next_r.state  = H_IDLE;
        end
      end
      default:
      begin
        next_r.state = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers; reset starts with a resync so a stuck sensor recovers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r       <= '0;
      r.state <= H_SEND;
      r.code  <= CMD_RESYNC;
      r.tx    <= RESYNC_PATTERN;
      r.left  <= 6'(RESYNC_LEN);
      r.din   <= RESYNC_PATTERN[20];
    end
    else if (ce)
      r <= next_r;
  end

  assign link.sclk    = r.sclk;
  assign link.din     = r.din;
  assign cmd_ready    = r.ready;
  assign result_valid = r.rvalid;
  assign result_data  = r.rdata;

endmodule : sensor_host

//--- logic/sensor_link_if.sv
// the three link wires between host and sensor
`timescale 1ns/100ps
interface sensor_link_if;
  logic sclk;
  logic din;
  logic dout;

  modport device (input sclk, input din, output dout);
  modport host   (output sclk, output din, input dout);
endinterface : sensor_link_if

//--- logic/sensor_link_pkg.sv
// shared constants and types for the sensor serial link
package sensor_link_pkg;

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  localparam logic [2:0]  START_BITS      = 3'h7;
  localparam logic [2:0]  STOP_BITS       = 3'h0;
  localparam int          CMD_LEN         = 10;
  localparam int          RESYNC_LEN      = 21;
  localparam logic [20:0] RESYNC_PATTERN  = 21'h155540;
  localparam logic [3:0]  SEL_PRESSURE    = 4'hA;
  localparam logic [3:0]  SEL_TEMPERATURE = 4'h9;
  localparam logic [3:0]  SEL_CAL_13      = 4'h5;
  localparam logic [3:0]  SEL_CAL_24      = 4'h6;

  // ----------------------------------------------------------------
  // clock counts per exchange
  // ----------------------------------------------------------------
  localparam logic [5:0]  ACK_CLOCKS      = 6'h02;
  localparam logic [5:0]  CONV_BITS       = 6'h10;
  localparam logic [5:0]  CAL_BITS        = 6'h20;
  localparam logic [5:0]  CONV_READ_CLKS  = 6'h11;
  localparam logic [5:0]  CAL_READ_CLKS   = 6'h21;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          SCLK_MIN_HALF_NS = 1000;
  localparam int          SCLK_HALF_CYC   = (SCLK_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          MCLK_HZ         = 32768;
  localparam int          CONV_TIME_MS    = 35;
  localparam int          SENSOR_ON_MS    = 2;
  localparam int          CONV_MCLK       = CONV_TIME_MS * MCLK_HZ / 1000;
  localparam int          SENSOR_ON_MCLK  = SENSOR_ON_MS * MCLK_HZ / 1000;

  // ----------------------------------------------------------------
  // host commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_PRESSURE    = 3'h0,
    CMD_TEMPERATURE = 3'h1,
    CMD_CAL_13      = 3'h2,
    CMD_CAL_24      = 3'h3,
    CMD_RESYNC      = 3'h4
  } host_cmd_t;

endpackage : sensor_link_pkg

//--- logic/sync_2ff.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  logic             clk,
  input  logic             rst,
  input  logic             ce,
  // levels
  input  logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t next_r;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("sync_2ff needs WIDTH of at least 1");
    end
  endgenerate

  always_comb
  begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  assign q = r.s2;

endmodule : sync_2ff

//--- test/pressure_sensor_serial_readout_bench.sv
// self-checking bench: host and sensor ends joined over the link
`timescale 1ns/100ps
module pressure_sensor_serial_readout_bench
  import sensor_link_pkg::*;
;
  // arbitrary calibration contents
  localparam logic [63:0] CALIB = 64'h0F1E_2D3C_4B5A_6978;

  logic        clk;
  logic        rst;
  logic        host_ce;
  logic        host_kick;
  logic        mclk;
  logic        cmd_valid;
  host_cmd_t   cmd_code;
  logic        cmd_ready;
  logic        result_valid;
  logic [31:0] result_data;
  logic [15:0] pressure_raw;
  logic [15:0] temperature_raw;
  logic        sensor_power;
  logic        conv_busy;
  logic [20:0] din_hist;
  logic [5:0]  rises;
  logic [37:0] expected_q[$];
  int          failures;
  int          checks;
  int          seed;

  sensor_link_if sensor_link_if_i ();

  always #5 clk = ~clk;
  always #62.5 mclk = ~mclk;

  sensor_host #(.SCLK_HALF(6)) sensor_host_i (
    .clk          (clk),
    .rst          (rst | host_kick),
    .ce           (host_ce),
    .cmd_valid    (cmd_valid),
    .cmd_code     (cmd_code),
    .cmd_ready    (cmd_ready),
    .result_valid (result_valid),
    .result_data  (result_data),
    .link         (sensor_link_if_i.host)
  );

  sensor_device #(.CONV_LEN(8), .POWER_LEN(2), .CALIB_DATA(CALIB)) sensor_device_i (
    .clk             (clk),
    .rst             (rst),
    .ce              (1'b1),
    .mclk            (mclk),
    .pressure_raw    (pressure_raw),
    .temperature_raw (temperature_raw),
    .sensor_power    (sensor_power),
    .conv_busy       (conv_busy),
    .link            (sensor_link_if_i.device)
  );

  sensor_link_monitor sensor_link_monitor_i (
    .clk          (clk),
    .rst          (rst | host_kick),
    .sclk         (sensor_link_if_i.sclk),
    .din          (sensor_link_if_i.din),
    .dout         (sensor_link_if_i.dout),
    .cmd_ready    (cmd_ready),
    .result_valid (result_valid),
    .cmd_code     (cmd_code),
    .conv_busy    (conv_busy),
    .sensor_power (sensor_power)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check_value(input logic [37:0] seen, input logic [37:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check_value

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 4000)
      check_value(38'h0, 38'h1);
  endtask : wait_ready

  // raw values stay put until the next command, as they are taken at conversion end
  task automatic run_cmd(input host_cmd_t code, input logic keep);
    logic [31:0] r;
    wait_ready();
    r = $random(seed);
    pressure_raw    <= r[15:0];
    temperature_raw <= r[31:16];
    cmd_valid       <= 1'b1;
    cmd_code        <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    rises = 6'h00;
    if (keep)
      case (code)
        CMD_PRESSURE:    expected_q.push_back({6'h1D, 16'h0000, r[15:0]});
        CMD_TEMPERATURE: expected_q.push_back({6'h1D, 16'h0000, r[31:16]});
        CMD_CAL_13:      expected_q.push_back({6'h2B, CALIB[63:48], CALIB[31:16]});
        CMD_CAL_24:      expected_q.push_back({6'h2B, CALIB[47:32], CALIB[15:0]});
        default:         ;
      endcase
    @(posedge clk);
  endtask : run_cmd

  // ------------------------------------------------------------
  // observers
  // ------------------------------------------------------------
  always @(posedge sensor_link_if_i.sclk)
  begin
    din_hist = {din_hist[19:0], sensor_link_if_i.din};
    rises    = rises + 6'h01;
  end

  always @(posedge clk)
  begin
    if (result_valid === 1'b1)
    begin
      if (expected_q.size() == 0)
      begin
        check_value(38'h0, 38'h1);
      end
      else
        check_value({rises, result_data}, expected_q.pop_front());
    end
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    clk             = 1'b0;
    mclk            = 1'b0;
    rst             = 1'b1;
    host_ce         = 1'b1;
    host_kick       = 1'b0;
    cmd_valid       = 1'b0;
    cmd_code        = CMD_PRESSURE;
    pressure_raw    = 16'h0000;
    temperature_raw = 16'h0000;
    din_hist        = 21'h000000;
    rises           = 6'h00;
    failures        = 0;
    checks          = 0;
    seed            = 32'hC54FD658;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wait_ready();
    check_value({17'h0, din_hist}, {17'h0, RESYNC_PATTERN});
    for (int i = 0; i < 12; i++)
      run_cmd(host_cmd_t'(3'(i % 4)), 1'b1);
    // hold the host mid-readout, then knock while it is busy
    run_cmd(CMD_PRESSURE, 1'b1);
    @(posedge sensor_link_if_i.dout);
    @(negedge sensor_link_if_i.dout);
    repeat (3) @(negedge sensor_link_if_i.sclk);
    @(posedge clk);
    host_ce <= 1'b0;
    repeat (60) @(posedge clk);
    host_ce   <= 1'b1;
    cmd_valid <= 1'b1;
    cmd_code  <= CMD_TEMPERATURE;
    @(posedge clk);
    cmd_valid <= 1'b0;
    run_cmd(CMD_RESYNC, 1'b0);
    wait_ready();
    check_value({17'h0, din_hist}, {17'h0, RESYNC_PATTERN});
    // host restarts mid calibration readout; its resync must free the device
    run_cmd(CMD_CAL_24, 1'b0);
    repeat (200) @(posedge clk);
    host_kick <= 1'b1;
    @(posedge clk);
    host_kick <= 1'b0;
    @(posedge clk);
    run_cmd(CMD_CAL_24, 1'b1);
    run_cmd(CMD_PRESSURE, 1'b1);
    wait_ready();
    check_value(38'(expected_q.size()), 38'h0);
    report_and_stop();
  end
endmodule : pressure_sensor_serial_readout_bench

//--- test/sensor_link_monitor.sv
// concurrent checks on the sensor link wires and the status of both ends
`timescale 1ns/100ps
module sensor_link_monitor
  import sensor_link_pkg::*;
(
  // clock and reset
  input logic      clk,
  input logic      rst,
  // link
  input logic      sclk,
  input logic      din,
  input logic      dout,
  // host status
  input logic      cmd_ready,
  input logic      result_valid,
  input host_cmd_t cmd_code,
  // device status
  input logic      conv_busy,
  input logic      sensor_power
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // run lengths of busy and power
  // ------------------------------------------------------------
  logic [7:0] busy_run;
  logic [7:0] power_run;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_run  <= 8'h00;
      power_run <= 8'h00;
    end
    else
    begin
      busy_run  <= conv_busy ? busy_run + 8'h01 : 8'h00;
      power_run <= sensor_power ? power_run + 8'h01 : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // offsets assume a sclk half period of 6 clk, as the bench sets
  // ------------------------------------------------------------
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("sclk high phase is not six cycles");
  AST_DIN_HOLD: assert property (sclk |-> $stable(din))
    else $error("din moved while sclk was high");
  AST_DOUT_LAUNCH:
    assert property ($rose(dout) |-> $past(sclk, 3) && !$past(sclk, 4))
    else $error("dout rose without a sclk rise three cycles before");
  AST_START:
    assert property ($fell(cmd_ready) && $past(cmd_code) != CMD_RESYNC
      |-> din throughout ##35 1'b1)
    else $error("command did not open with three high bits");
  AST_STOP:
    assert property ($fell(cmd_ready) && $past(cmd_code) != CMD_RESYNC
      |-> ##84 (!din throughout ##35 1'b1))
    else $error("command did not close with three low bits");
  AST_CONV_ACK:
    assert property ($fell(cmd_ready) && $past(cmd_code) inside {CMD_PRESSURE, CMD_TEMPERATURE}
      |-> ##116 !dout ##1 dout ##27 (!sclk throughout ##60 1'b1))
    else $error("conversion acknowledge or quiet sclk missing");
  AST_CAL_NO_ACK:
    assert property ($fell(cmd_ready) && $past(cmd_code) inside {CMD_CAL_13, CMD_CAL_24}
      |-> ##117 !dout)
    else $error("calibration read raised an acknowledge");
  AST_CONV_END:
    assert property ($fell(conv_busy)
      |-> busy_run >= 8'h50 && busy_run <= 8'h73 ##[0:2] !dout)
    else $error("conversion length wrong or dout not low at its end");
  AST_POWER: assert property (sensor_power |-> conv_busy && power_run < 8'h28)
    else $error("sensing element powered too long or outside conversion");
  AST_RESULT: assert property (result_valid |-> !cmd_ready ##1 (cmd_ready && !result_valid))
    else $error("result pulse not followed by ready");
  AST_READY_IDLE: assert property (cmd_ready |-> !sclk && !conv_busy)
    else $error("link active while host idle");

  cover property ($rose(conv_busy));
  cover property ($fell(sensor_power));
  cover property (result_valid);
endmodule : sensor_link_monitor
